// >>> design/pin_change_cfg.svh
`ifndef PIN_CHANGE_CFG_SVH
`define PIN_CHANGE_CFG_SVH

// Register byte offsets on the AHB-Lite bus.
`define OFS_PORTA_RISE_ENABLE 12'h000
`define OFS_PORTA_FALL_ENABLE 12'h004
`define OFS_PORTA_CHANGE_FLAGS 12'h008
`define OFS_PORTB_RISE_ENABLE 12'h00C
`define OFS_PORTB_FALL_ENABLE 12'h010
`define OFS_PORTB_CHANGE_FLAGS 12'h014
`define OFS_IRQ_CONTROL 12'h018
`define OFS_IRQ_STATUS 12'h01C
`define OFS_IRQ_MASK 12'h020

// Implemented bit masks of the two ports.
`define PORTA_IMPL_MASK 8'h3F
`define PORTB_IMPL_MASK 8'hF0

// Field positions in the control and status registers.
`define CTRL_MASTER_ENABLE_BIT 0
`define CTRL_SUMMARY_FLAG_BIT 1
`define CTRL_WAKE_BIT 2
`define STAT_PORTA_EVENT_BIT 0
`define STAT_PORTB_EVENT_BIT 1
`define STAT_WIDTH 2

// Reset values.
`define RESET_BYTE 8'h00
`define RESET_STAT 2'b00

`endif

// >>> design/pin_change_pkg.sv
package pin_change_pkg;

	// Bus transfer types used by the slave.
	typedef enum logic [1:0]
	{
		HTRANS_IDLE = 2'b00,
		HTRANS_BUSY = 2'b01,
		HTRANS_NONSEQ = 2'b10,
		HTRANS_SEQ = 2'b11
	} htrans_e;

	// Data phase state of the bus slave.
	typedef enum logic [1:0]
	{
		PH_IDLE = 2'b01,
		PH_DATA = 2'b10
	} phase_e;

	typedef logic [7:0] byte_t;

endpackage : pin_change_pkg

// >>> design/pin_sync.sv
// ************************************************************
// Two-stage synchroniser for a vector of pins.
// ************************************************************
module pin_sync
#(
	parameter int WIDTH = 8
)
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Asynchronous input and synchronised output.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : pin_sync

// >>> design/edge_flags.sv
// ************************************************************
// Edge detectors and sticky change flags for one port.
// ************************************************************
module edge_flags
#(
	parameter logic [7:0] IMPL_MASK = 8'hFF
)
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Synchronised pins and enables.
	input wire logic [7:0] pins_sync,
	input wire logic [7:0] rise_enable,
	input wire logic [7:0] fall_enable,
	// Software write to the flag register.
	input wire logic flag_write,
	input wire logic [7:0] flag_wdata,
	// Flag state and per-cycle detections.
	output logic [7:0] flags,
	output logic [7:0] detect
);

	logic [7:0] prev_q;
	logic [7:0] rise;
	logic [7:0] fall;

	// Previous sampled pin value for edge comparison.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			prev_q <= 8'h00;
		else
			prev_q <= pins_sync;
	end

	// Independent rise and fall detectors per pin, armed by their enables.
	assign rise = pins_sync & ~prev_q & rise_enable;
	assign fall = ~pins_sync & prev_q & fall_enable;
	assign detect = (rise | fall) & IMPL_MASK;

	// Flags are written by software; a detection in the same cycle wins.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flags <= 8'h00;
		else if (flag_write)
			flags <= ((flag_wdata & IMPL_MASK) | detect);
		else
			flags <= flags | detect;
	end

endmodule : edge_flags

// >>> design/pin_change_interrupt.sv
`include "pin_change_cfg.svh"

module pin_change_interrupt
	import pin_change_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Port pins.
	input wire logic [7:0] first_port_pin,
	input wire logic [7:0] second_port_pin,
	// Requests to the core.
	output logic change_irq_request,
	output logic wake_request,
	output logic irq
);

	// ************************************************************
	// Registers and signals
	// ************************************************************
	byte_t porta_rise_enable_q;
	byte_t porta_fall_enable_q;
	byte_t portb_rise_enable_q;
	byte_t portb_fall_enable_q;
	logic change_irq_master_enable_q;
	logic [`STAT_WIDTH-1:0] irq_status_q;
	logic [`STAT_WIDTH-1:0] irq_mask_q;
	phase_e phase_q;
	logic [11:0] addr_q;
	logic write_q;
	logic [7:0] porta_sync;
	logic [7:0] portb_sync;
	logic [7:0] porta_flags;
	logic [7:0] portb_flags;
	logic [7:0] porta_detect;
	logic [7:0] portb_detect;
	logic change_irq_summary_flag;
	logic any_detect;
	logic wr_strobe;
	logic [`STAT_WIDTH-1:0] events;
	logic [31:0] rdata_d;
	logic porta_flag_write;
	logic portb_flag_write;
	logic bus_accept;
	logic rd_accept;

	// ************************************************************
	// Pin synchronisers and per-port edge logic
	// ************************************************************
	pin_sync #(.WIDTH(8)) u_sync_a
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(first_port_pin),
		.sync_out(porta_sync)
	);

	pin_sync #(.WIDTH(8)) u_sync_b
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(second_port_pin),
		.sync_out(portb_sync)
	);

	edge_flags #(.IMPL_MASK(`PORTA_IMPL_MASK)) u_flags_a
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.pins_sync(porta_sync),
		.rise_enable(porta_rise_enable_q),
		.fall_enable(porta_fall_enable_q),
		.flag_write(porta_flag_write),
		.flag_wdata(hwdata[7:0]),
		.flags(porta_flags),
		.detect(porta_detect)
	);

	edge_flags #(.IMPL_MASK(`PORTB_IMPL_MASK)) u_flags_b
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.pins_sync(portb_sync),
		.rise_enable(portb_rise_enable_q),
		.fall_enable(portb_fall_enable_q),
		.flag_write(portb_flag_write),
		.flag_wdata(hwdata[7:0]),
		.flags(portb_flags),
		.detect(portb_detect)
	);

	// ************************************************************
	// Bus slave
	// ************************************************************

	// Address phase is captured when a valid transfer is selected.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase_q <= PH_IDLE;
			addr_q <= 12'h000;
			write_q <= 1'b0;
		end
		else if (hready)
		begin
			if (hsel && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ))
			begin
				phase_q <= PH_DATA;
				addr_q <= haddr;
				write_q <= hwrite;
			end
			else
			begin
				phase_q <= PH_IDLE;
				write_q <= 1'b0;
			end
		end
	end

	// A transfer is accepted when the slave is selected for a NONSEQ or SEQ transfer in a ready cycle.
	assign bus_accept = hready && hsel && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign rd_accept = bus_accept && !hwrite;

	// ************************************************************
	// Bus response
	// ************************************************************

	// The slave never inserts a wait state; ready comes from a flip-flop.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hreadyout <= 1'b1;
		else
			hreadyout <= 1'b1;
	end

	// Every transfer is answered OKAY.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// Write strobes in the data phase.
	assign wr_strobe = (phase_q == PH_DATA) && write_q;
	assign porta_flag_write = wr_strobe && (addr_q == `OFS_PORTA_CHANGE_FLAGS);
	assign portb_flag_write = wr_strobe && (addr_q == `OFS_PORTB_CHANGE_FLAGS);

	// ************************************************************
	// Edge enable registers
	// ************************************************************

	// First port rising-edge enables, masked to implemented bits.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			porta_rise_enable_q <= `RESET_BYTE;
		else if (wr_strobe && addr_q == `OFS_PORTA_RISE_ENABLE)
			porta_rise_enable_q <= hwdata[7:0] & `PORTA_IMPL_MASK;
	end

	// First port falling-edge enables, masked to implemented bits.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			porta_fall_enable_q <= `RESET_BYTE;
		else if (wr_strobe && addr_q == `OFS_PORTA_FALL_ENABLE)
			porta_fall_enable_q <= hwdata[7:0] & `PORTA_IMPL_MASK;
	end

	// Second port rising-edge enables, masked to implemented bits.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			portb_rise_enable_q <= `RESET_BYTE;
		else if (wr_strobe && addr_q == `OFS_PORTB_RISE_ENABLE)
			portb_rise_enable_q <= hwdata[7:0] & `PORTB_IMPL_MASK;
	end

	// Second port falling-edge enables, masked to implemented bits.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			portb_fall_enable_q <= `RESET_BYTE;
		else if (wr_strobe && addr_q == `OFS_PORTB_FALL_ENABLE)
			portb_fall_enable_q <= hwdata[7:0] & `PORTB_IMPL_MASK;
	end

	// ************************************************************
	// Control and mask registers
	// ************************************************************

	// Master enable gates the change request and wake, never the flags or irq.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			change_irq_master_enable_q <= 1'b0;
		else if (wr_strobe && addr_q == `OFS_IRQ_CONTROL)
			change_irq_master_enable_q <= hwdata[`CTRL_MASTER_ENABLE_BIT];
	end

	// Mask of the interrupt status bits.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_mask_q <= `RESET_STAT;
		else if (wr_strobe && addr_q == `OFS_IRQ_MASK)
			irq_mask_q <= hwdata[`STAT_WIDTH-1:0];
	end

	// ************************************************************
	// Flags, requests and interrupt status
	// ************************************************************

	// Summary flag is a read-only OR of every per-pin flag.
	assign change_irq_summary_flag = |{porta_flags, portb_flags};
	assign any_detect = |{porta_detect, portb_detect};
	assign events = {|portb_detect, |porta_detect};

	// ************************************************************
	// Requests to the core
	// ************************************************************

	// Request follows the summary flag, gated by master enable.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			change_irq_request <= 1'b0;
		else
			change_irq_request <= change_irq_master_enable_q &
				(change_irq_summary_flag | any_detect);
	end

	// Wake pulses once per detected edge; the flag is set on the same edge.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wake_request <= 1'b0;
		else
			wake_request <= change_irq_master_enable_q & any_detect;
	end

	// Sticky event status; a new event wins over a write-one clear.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_status_q <= `RESET_STAT;
		else if (wr_strobe && addr_q == `OFS_IRQ_STATUS)
			irq_status_q <= (irq_status_q & ~hwdata[`STAT_WIDTH-1:0]) | events;
		else
			irq_status_q <= irq_status_q | events;
	end

	// Level interrupt from unmasked status bits.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status_q & irq_mask_q);
	end

	// ************************************************************
	// Register read-back
	// ************************************************************

	// Read multiplexer on the address phase; unmapped addresses read zero.
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (haddr)
			`OFS_PORTA_RISE_ENABLE: rdata_d[7:0] = porta_rise_enable_q;
			`OFS_PORTA_FALL_ENABLE: rdata_d[7:0] = porta_fall_enable_q;
			`OFS_PORTA_CHANGE_FLAGS: rdata_d[7:0] = porta_flags;
			`OFS_PORTB_RISE_ENABLE: rdata_d[7:0] = portb_rise_enable_q;
			`OFS_PORTB_FALL_ENABLE: rdata_d[7:0] = portb_fall_enable_q;
			`OFS_PORTB_CHANGE_FLAGS: rdata_d[7:0] = portb_flags;
			`OFS_IRQ_CONTROL:
			begin
				rdata_d[`CTRL_MASTER_ENABLE_BIT] = change_irq_master_enable_q;
				rdata_d[`CTRL_SUMMARY_FLAG_BIT] = change_irq_summary_flag;
				rdata_d[`CTRL_WAKE_BIT] = wake_request;
			end
			`OFS_IRQ_STATUS: rdata_d[`STAT_WIDTH-1:0] = irq_status_q;
			`OFS_IRQ_MASK: rdata_d[`STAT_WIDTH-1:0] = irq_mask_q;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// Read data is registered at the address phase and stands for the data phase.
	// A read issued right after a write to the same register sees the old value,
	// so software leaves one idle cycle between them.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (rd_accept)
			hrdata <= rdata_d;
		else
			hrdata <= 32'h0000_0000;
	end

endmodule : pin_change_interrupt

// >>> verification/pin_source.sv
// ****
// Outside circuit that drives both ports.
// ****
module pin_source
(
	// Clock.
	input wire logic hclk,
	// Pin levels.
	output logic [7:0] pa,
	output logic [7:0] pb
);
	timeunit 1ns;
	timeprecision 1ns;

	// Both ports start low.
	initial
	begin
		pa = 8'h00;
		pb = 8'h00;
	end

	// New levels come just after an edge; callers hold them two cycles or more.
	task automatic drive(input logic [7:0] na, input logic [7:0] nb);
		@(posedge hclk);
		pa <= na;
		pb <= nb;
	endtask : drive
endmodule : pin_source

// >>> verification/pin_change_interrupt_props.sv
// ****
// Port checks of the change block.
// ****
module pin_change_interrupt_chk
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Bus side.
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Pins and requests.
	input wire logic [7:0] first_port_pin,
	input wire logic [7:0] second_port_pin,
	input wire logic change_irq_request,
	input wire logic wake_request,
	input wire logic irq
);
	logic [7:0] pa_q, pb_q, chg_q;
	logic [5:0] wr_q;
	logic wp_q;
	wire logic acc = hsel && hready && htrans[1];

	// Recent changes of used pins and recent writes, as causes of output moves.
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			pa_q <= 8'h00;
			pb_q <= 8'h00;
			chg_q <= 8'h00;
			wp_q <= 1'b0;
			wr_q <= 6'h00;
		end
		else
		begin
			pa_q <= first_port_pin;
			pb_q <= second_port_pin;
			chg_q <= {chg_q[6:0], |((first_port_pin ^ pa_q) & 8'h3F | (second_port_pin ^ pb_q) & 8'hF0)};
			wp_q <= acc && hwrite;
			wr_q <= {wr_q[4:0], wp_q};
		end

	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Steps that the properties are built from.
	sequence s_read_a;
		acc && !hwrite && haddr <= 12'h008;
	endsequence
	sequence s_read_b;
		acc && !hwrite && haddr >= 12'h00C && haddr <= 12'h014;
	endsequence
	sequence s_wrote;
		|wr_q;
	endsequence
	sequence s_moved;
		|chg_q;
	endsequence

	property p_read_a;
		s_read_a |=> hrdata[31:6] == '0;
	endproperty
	property p_read_b;
		s_read_b |=> hrdata[31:8] == '0 && hrdata[3:0] == 4'h0;
	endproperty
	property p_wake_cause;
		wake_request |-> s_moved;
	endproperty
	property p_wake_req;
		wake_request |-> change_irq_request;
	endproperty
	property p_req_rise;
		$rose(change_irq_request) |-> |chg_q || |wr_q;
	endproperty
	property p_req_fall;
		$fell(change_irq_request) |-> s_wrote;
	endproperty
	property p_irq_fall;
		$fell(irq) |-> s_wrote;
	endproperty
	property p_bus_ok;
		hreadyout && !hresp;
	endproperty

	a_read_a: assert property (p_read_a) else $error("port A unused bits");
	a_read_b: assert property (p_read_b) else $error("port B unused bits");
	a_wake_cause: assert property (p_wake_cause) else $error("wake w/o pin");
	a_wake_req: assert property (p_wake_req) else $error("wake w/o request");
	a_req_rise: assert property (p_req_rise) else $error("request w/o cause");
	a_req_fall: assert property (p_req_fall) else $error("request dropped");
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
	a_bus_ok: assert property (p_bus_ok) else $error("bus not ready");
endmodule : pin_change_interrupt_chk

bind pin_change_interrupt pin_change_interrupt_chk u_chk
(
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .first_port_pin(first_port_pin), .second_port_pin(second_port_pin),
	.change_irq_request(change_irq_request), .wake_request(wake_request), .irq(irq)
);

// >>> verification/test_pin_change_interrupt.sv
// ****
// Bench for the change block.
// ****
module test_pin_change_interrupt
	import pin_change_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hsel, hwrite;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, rdv;
	wire logic [31:0] hrdata;
	wire logic rdy, req, wake, irq;
	wire logic [7:0] pa, pb;
	int failures, comparisons;

	// Clock with a 20 ns period.
	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	pin_change_interrupt DUT
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
		.hreadyout(rdy), .hresp(), .first_port_pin(pa), .second_port_pin(pb),
		.change_irq_request(req), .wake_request(wake), .irq(irq)
	);
	pin_source u_pins (.hclk(hclk), .pa(pa), .pb(pb));

	task automatic print_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	// Waits for a ready edge; a stuck bus ends the run.
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (rdy !== 1'b1 && n < 20)
		begin
			@(posedge hclk);
			n++;
		end
		if (n == 20)
		begin
			failures++;
			print_verdict;
		end
	endtask : wait_ready

	// One single word transfer; read data lands in rdv.
	task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		wait_ready;
		htrans <= HTRANS_IDLE;
		hwdata <= {24'h0, d};
		wait_ready;
		rdv = hrdata;
	endtask : bus

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h0);
		check(rdv, exp);
	endtask : rd

	// Polls wake (0), request (1) or irq (2) for a bounded time.
	task automatic await(input int s);
		int n;
		n = 0;
		while (n < 12 && (s == 0 ? wake : s == 1 ? req : irq) !== 1'b1)
		begin
			@(posedge hclk);
			#1;
			n++;
		end
		check({31'h0, n < 12}, 32'h1);
		if (n == 12)
			print_verdict;
	endtask : await

	task automatic s_regs;
		for (int i = 0; i < 6; i++)
		begin
			bus(1'b1, 12'(4 * i), 8'hFF);
			rd(12'(4 * i), i % 3 == 2 || i < 2 ? (i < 3 ? 32'h3F : 32'hF0) : 32'hF0);
		end
		bus(1'b1, 12'h024, 8'hFF);
		rd(12'h024, 32'h0);
		rd(12'h018, 32'h2);
		bus(1'b1, 12'h008, 8'h00);
		bus(1'b1, 12'h014, 8'h00);
		bus(1'b1, 12'h018, 8'h02);
		rd(12'h018, 32'h0);
	endtask : s_regs

	task automatic s_edges;
		bus(1'b1, 12'h000, 8'h01);
		bus(1'b1, 12'h004, 8'h02);
		bus(1'b1, 12'h00C, 8'h90);
		bus(1'b1, 12'h010, 8'hA0);
		u_pins.drive(8'hC3, 8'hFF);
		repeat (6) @(posedge hclk);
		rd(12'h008, 32'h01);
		rd(12'h014, 32'h90);
		u_pins.drive(8'h00, 8'h00);
		repeat (6) @(posedge hclk);
		rd(12'h008, 32'h03);
		rd(12'h014, 32'hB0);
		check({31'h0, req}, 32'h0);
		rd(12'h008, 32'h03);
		bus(1'b1, 12'h008, (8'hFF ^ rdv[7:0]) & rdv[7:0]);
		rd(12'h008, 32'h0);
		bus(1'b1, 12'h014, 8'h00);
	endtask : s_edges

	task automatic s_irq;
		bus(1'b1, 12'h01C, 8'h03);
		bus(1'b1, 12'h018, 8'h01);
		bus(1'b1, 12'h020, 8'h01);
		u_pins.drive(8'h01, 8'h00);
		await(0);
		await(1);
		await(2);
		rd(12'h01C, 32'h1);
		u_pins.drive(8'h01, 8'h80);
		repeat (8) @(posedge hclk);
		rd(12'h01C, 32'h3);
		check({31'h0, irq}, 32'h1);
		bus(1'b1, 12'h01C, 8'h01);
		repeat (3) @(posedge hclk);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, 12'h020, 8'h03);
		await(2);
		u_pins.drive(8'h01, 8'h00);
		bus(1'b1, 12'h014, 8'h00);
		rd(12'h014, 32'h80);
	endtask : s_irq

	initial
	begin
		failures = 0;
		comparisons = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 12'h0;
		htrans = HTRANS_IDLE;
		hwdata = 32'h0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		for (int a = 0; a <= 'h24; a += 4)
			rd(12'(a), 32'h0);
		s_regs;
		s_edges;
		s_irq;
		print_verdict;
	end
endmodule : test_pin_change_interrupt
